// >>> hw/bms_sequencer.sv
`timescale 1ns/100ps
module bms_sequencer
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic word_mode,
  input wire logic [bms_pkg::CNT_W-1:0] count_word_in,
  input wire logic [bms_pkg::ADDR_W-1:0] source_pointer_in,
  input wire logic [bms_pkg::ADDR_W-1:0] destination_pointer_in,
  input wire logic mem_slow_wait,
  input wire logic [bms_pkg::DATA_W-1:0] mem_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [bms_pkg::ADDR_W-1:0] mem_addr,
  output logic [bms_pkg::DATA_W-1:0] mem_wdata,
  output logic busy,
  output logic done,
  output logic [bms_pkg::CNT_W-1:0] count_word,
  output logic [bms_pkg::ADDR_W-1:0] source_pointer,
  output logic [bms_pkg::ADDR_W-1:0] destination_pointer,
  input wire bms_pkg::bms_fop_t flag_op,
  input wire logic flag_strobe,
  input wire logic [31:0] flag_a,
  input wire logic [31:0] flag_b,
  input wire logic [31:0] flag_res,
  input wire logic flag_zero_note,
  input wire logic flag_adj_carry,
  output logic flag_half,
  output logic flag_zero,
  output logic flag_carry,
  output logic flag_neg_div,
  output logic flag_zero_div,
  output logic flag_neg_quot
);
  import bms_pkg::*;

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  bms_state_t state_q, state_d;
  logic [4:0] tick_q, tick_d;
  logic word_q, word_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] src_q, src_d;
  logic [ADDR_W-1:0] dst_q, dst_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic cnt_zero;

  // The active counter is the low byte or the full word.
  function automatic logic count_is_zero(input logic w, input logic [CNT_W-1:0] c);
    count_is_zero = w ? (c == ZERO16) : (c[7:0] == 8'h00);
  endfunction : count_is_zero

  assign cnt_zero = count_is_zero(word_q, cnt_q);

  // Next-state logic of the move sequencer.
  always_comb
  begin
    state_d = state_q;
    tick_d = tick_q;
    word_d = word_q;
    cnt_d = cnt_q;
    src_d = src_q;
    dst_d = dst_q;
    data_d = data_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    addr_d = addr_q;
    done_d = 1'b0;
    unique case (state_q)
      BMS_IDLE:
      begin
        if (start)
        begin
          state_d = BMS_SETUP;
          tick_d = SETUP_STATES - 5'h02;
          word_d = word_mode;
          cnt_d = count_word_in;
          src_d = source_pointer_in;
          dst_d = destination_pointer_in;
        end
      end
      BMS_SETUP:
      begin
        if (tick_q != 5'h00)
        begin
          tick_d = tick_q - 5'h01;
        end
        else if (cnt_zero)
        begin
          state_d = BMS_DONE;
        end
        else
        begin
          state_d = BMS_READ;
          rd_d = 1'b1;
          addr_d = src_q;
          tick_d = {2'b00, READ_STATES} - 5'h01;
        end
      end
      BMS_READ:
      begin
        if (mem_slow_wait)
        begin
          rd_d = 1'b1;
        end
        else if (tick_q != 5'h00)
        begin
          rd_d = 1'b1;
          tick_d = tick_q - 5'h01;
        end
        else
        begin
          state_d = BMS_WRITE;
          data_d = mem_rdata;
          wr_d = 1'b1;
          addr_d = dst_q;
        end
      end
      BMS_WRITE:
      begin
        if (mem_slow_wait)
        begin
          wr_d = wr_q;
        end
        else
        begin
          state_d = BMS_STEP;
        end
      end
      BMS_STEP:
      begin
        src_d = src_q + ONE16;
        dst_d = dst_q + ONE16;
        cnt_d = word_q ? (cnt_q - ONE16) : {cnt_q[15:8], cnt_q[7:0] - 8'h01};
        if (count_is_zero(word_q, cnt_d))
        begin
          state_d = BMS_DONE;
        end
        else
        begin
          state_d = BMS_READ;
          rd_d = 1'b1;
          addr_d = src_d;
          tick_d = {2'b00, READ_STATES} - 5'h01;
        end
      end
      BMS_DONE:
      begin
        done_d = 1'b1;
        state_d = BMS_IDLE;
      end
      default:
      begin
        state_d = BMS_IDLE;
      end
    endcase
    // Busy is registered from the next state so that it leaves a flip-flop.
    busy_d = (state_d != BMS_IDLE);
  end

  // Registers of the move sequencer.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= BMS_IDLE;
      tick_q <= 5'h00;
      word_q <= 1'b0;
      cnt_q <= ZERO16;
      src_q <= ZERO16;
      dst_q <= ZERO16;
      data_q <= 8'h00;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= ZERO16;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tick_q <= tick_d;
      word_q <= word_d;
      cnt_q <= cnt_d;
      src_q <= src_d;
      dst_q <= dst_d;
      data_q <= data_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign mem_rd = rd_q;
  assign mem_wr = wr_q;
  assign mem_addr = addr_q;
  assign mem_wdata = data_q;
  assign busy = busy_q;
  assign done = done_q;
  assign count_word = cnt_q;
  assign source_pointer = src_q;
  assign destination_pointer = dst_q;

  // ---------------------------------------------------------------------------
  // Condition-code flags.
  // ---------------------------------------------------------------------------
  bms_flag_if fif ();
  logic half_q, half_d, zero_q, zero_d, carry_q, carry_d;
  logic ndiv_q, ndiv_d, zdiv_q, zdiv_d, nquo_q, nquo_d;

  assign fif.op = flag_op;
  assign fif.a = flag_a;
  assign fif.b = flag_b;
  assign fif.res = flag_res;
  assign fif.res_zero_flag_en = flag_zero_note;
  assign fif.adj_carry = flag_adj_carry;
  assign fif.zero_in = zero_q;
  assign fif.carry_in = carry_q;

  bms_flag_unit u_flag
  (
    .f(fif.unit)
  );

  // Flags update only on a strobed operation.
  always_comb
  begin
    half_d = half_q;
    zero_d = zero_q;
    carry_d = carry_q;
    ndiv_d = ndiv_q;
    zdiv_d = zdiv_q;
    nquo_d = nquo_q;
    if (flag_strobe)
    begin
      if (flag_op inside {BMS_FOP_ADDW, BMS_FOP_SUBW, BMS_FOP_ADDL, BMS_FOP_SUBL})
      begin
        half_d = fif.half;
      end
      zero_d = fif.zero;
      carry_d = fif.carry;
      if (flag_op == BMS_FOP_DIVS || flag_op == BMS_FOP_DIVU)
      begin
        ndiv_d = fif.neg_div;
        zdiv_d = fif.zero_div;
        nquo_d = fif.neg_quot;
      end
    end
  end

  // Flag registers.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      half_q <= 1'b0;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
      ndiv_q <= 1'b0;
      zdiv_q <= 1'b0;
      nquo_q <= 1'b0;
    end
    else
    begin
      half_q <= half_d;
      zero_q <= zero_d;
      carry_q <= carry_d;
      ndiv_q <= ndiv_d;
      zdiv_q <= zdiv_d;
      nquo_q <= nquo_d;
    end
  end

  assign flag_half = half_q;
  assign flag_zero = zero_q;
  assign flag_carry = carry_q;
  assign flag_neg_div = ndiv_q;
  assign flag_zero_div = zdiv_q;
  assign flag_neg_quot = nquo_q;

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  property p_zero_skip;
    @(posedge clk) disable iff (!reset_n)
    (state_q == BMS_SETUP && tick_q == 5'h00 && cnt_zero) |=> (state_q == BMS_DONE && !mem_rd);
  endproperty
  a_zero_skip: assert property (p_zero_skip) else $error("Zero count started a transfer.");

  property p_read_then_write;
    @(posedge clk) disable iff (!reset_n)
    $rose(mem_rd) && !mem_slow_wait ##1 !mem_slow_wait |-> ##1 mem_wr;
  endproperty
  a_read_then_write: assert property (p_read_then_write) else $error("Write did not follow read.");

  property p_step;
    @(posedge clk) disable iff (!reset_n)
    (state_q == BMS_STEP) |=> (src_q == $past(src_q) + ONE16 && dst_q == $past(dst_q) + ONE16);
  endproperty
  a_step: assert property (p_step) else $error("Pointers did not advance by one.");

  property p_setup_len;
    @(posedge clk) disable iff (!reset_n)
    (state_q == BMS_IDLE && start) |-> ##7 (state_q == BMS_SETUP) ##1 (state_q != BMS_SETUP);
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("Setup did not take eight states.");

  property p_stall;
    @(posedge clk) disable iff (!reset_n)
    (mem_wr && mem_slow_wait) |=> mem_wr;
  endproperty
  a_stall: assert property (p_stall) else $error("Write dropped during stall.");

  property p_word_stop;
    @(posedge clk) disable iff (!reset_n)
    (state_q == BMS_STEP && word_q && cnt_q == ONE16) |=> (state_q == BMS_DONE && cnt_q == ZERO16);
  endproperty
  a_word_stop: assert property (p_word_stop) else $error("Word count did not end at zero.");

  property p_zdiv;
    @(posedge clk) disable iff (!reset_n)
    (flag_strobe && flag_op == BMS_FOP_DIVU && flag_b[15:0] == ZERO16) |=> flag_zero_div;
  endproperty
  a_zdiv: assert property (p_zdiv) else $error("Zero divisor flag not set.");

  property p_adj;
    @(posedge clk) disable iff (!reset_n)
    (flag_strobe && flag_op == BMS_FOP_ADJ && !flag_adj_carry) |=> (flag_carry == $past(flag_carry));
  endproperty
  a_adj: assert property (p_adj) else $error("Adjust carry not kept.");

  property p_zero_note;
    @(posedge clk) disable iff (!reset_n)
    (flag_strobe && flag_zero_note) |=> (flag_zero == ($past(flag_res) == 32'h0000_0000 && $past(flag_zero)));
  endproperty
  a_zero_note: assert property (p_zero_note) else $error("Noted zero flag not kept or cleared.");

endmodule : bms_sequencer

// >>> hw/bms_pkg.sv
package bms_pkg;

  // ---------------------------------------------------------------------------
  // Widths.
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // ---------------------------------------------------------------------------
  // Timing in CPU states.
  // ---------------------------------------------------------------------------
  localparam logic [4:0] SETUP_STATES = 5'h08;
  localparam logic [2:0] STATES_PER_BYTE = 3'h4;
  localparam logic [2:0] READ_STATES = 3'h2;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ---------------------------------------------------------------------------
  // Flag operation selects and bit positions.
  // ---------------------------------------------------------------------------
  localparam int HALF_BIT_WORD = 11;
  localparam int HALF_BIT_LONG = 27;

  typedef enum logic [2:0] {
    BMS_FOP_NONE = 3'b000,
    BMS_FOP_ADDW = 3'b001,
    BMS_FOP_SUBW = 3'b010,
    BMS_FOP_ADDL = 3'b011,
    BMS_FOP_SUBL = 3'b100,
    BMS_FOP_DIVS = 3'b101,
    BMS_FOP_DIVU = 3'b110,
    BMS_FOP_ADJ = 3'b111
  } bms_fop_t;

  typedef enum logic [2:0] {
    BMS_IDLE = 3'b000,
    BMS_SETUP = 3'b001,
    BMS_READ = 3'b010,
    BMS_WRITE = 3'b011,
    BMS_STEP = 3'b100,
    BMS_DONE = 3'b101
  } bms_state_t;

endpackage : bms_pkg

// >>> hw/bms_flag_if.sv
`timescale 1ns/100ps
// Operand bundle from the sequencer to the flag unit.
interface bms_flag_if;
  import bms_pkg::*;
  bms_fop_t op;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] res;
  logic res_zero_flag_en;
  logic adj_carry;
  logic half;
  logic zero_in;
  logic zero;
  logic carry_in;
  logic carry;
  logic neg_div;
  logic zero_div;
  logic neg_quot;
  modport src (output op, a, b, res, res_zero_flag_en, adj_carry, zero_in, carry_in,
    input half, zero, carry, neg_div, zero_div, neg_quot);
  modport unit (input op, a, b, res, res_zero_flag_en, adj_carry, zero_in, carry_in,
    output half, zero, carry, neg_div, zero_div, neg_quot);
endinterface : bms_flag_if

// >>> hw/bms_flag_unit.sv
`timescale 1ns/100ps
// Condition-code side rules applied to a finished operation.
module bms_flag_unit
(
  bms_flag_if.unit f
);
  import bms_pkg::*;

  // ---------------------------------------------------------------------------
  // Flag computation.
  // ---------------------------------------------------------------------------

  // Carry into a bit is a xor b xor result; the carry out of bit k is the carry into k+1.
  function automatic logic carry_out(input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] r, input int k);
    logic [31:0] x;
    x = a ^ b ^ r;
    carry_out = x[k + 1];
  endfunction : carry_out

  // Combinational flag rules.
  always_comb
  begin
    f.half = 1'b0;
    if (f.op == BMS_FOP_ADDW || f.op == BMS_FOP_SUBW)
    begin
      f.half = carry_out(f.a, f.b, f.res, HALF_BIT_WORD);
    end
    if (f.op == BMS_FOP_ADDL || f.op == BMS_FOP_SUBL)
    begin
      f.half = carry_out(f.a, f.b, f.res, HALF_BIT_LONG);
    end
    // sticky zero
    // Without the note the zero flag simply follows the result.
    f.zero = f.res_zero_flag_en ? ((f.res == 32'h0000_0000) ? f.zero_in : 1'b0) : (f.res == 32'h0000_0000);
    f.carry = (f.op == BMS_FOP_ADJ && f.adj_carry) ? 1'b1 : f.carry_in;
    f.neg_div = (f.op == BMS_FOP_DIVS) && f.b[15];
    f.zero_div = (f.op == BMS_FOP_DIVS || f.op == BMS_FOP_DIVU) && (f.b[15:0] == ZERO16);
    f.neg_quot = (f.op == BMS_FOP_DIVS || f.op == BMS_FOP_DIVU) && f.res[15];
  end

endmodule : bms_flag_unit

// >>> tb/bms_mem_model.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// On-chip memory model with an optional slow-clock stall.
// -----------------------------------------------------------------------------
module bms_mem_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [bms_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [bms_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_slow_wait,
  output logic [bms_pkg::DATA_W-1:0] mem_rdata
);
  import bms_pkg::*;
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] last_q;
  logic rd_waited_q;
  logic wr_waited_q;
  int wr_count;
  int stall_count;

  // Memory starts from a fixed pattern so that copies can be predicted.
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end

  // one stall per read and per write
  assign mem_slow_wait = slow && ((mem_rd && !rd_waited_q) || (mem_wr && !wr_waited_q));
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q; // Undriven data never repeats the last byte.

  // Stores accepted writes and counts stall cycles.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_waited_q <= 1'b0;
      wr_waited_q <= 1'b0;
      last_q <= 8'h00;
    end
    else
    begin
      rd_waited_q <= mem_rd && (rd_waited_q || slow);
      wr_waited_q <= mem_wr && (wr_waited_q || slow);
      if (mem_rd)
        last_q <= mem_rdata;
      if (mem_slow_wait)
        stall_count++;
      if (mem_wr && !mem_slow_wait)
      begin
        mem[mem_addr] <= mem_wdata;
        wr_count++;
      end
    end
  end
endmodule : bms_mem_model

// >>> tb/bms_sequencer_tb.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// Self-checking bench for the block move sequencer and its flag rules.
// -----------------------------------------------------------------------------
module bms_sequencer_tb;
  import bms_pkg::*;
  logic clk, reset_n, start, word_mode, slow, mem_slow_wait, mem_rd, mem_wr, busy, done;
  logic flag_strobe, flag_zero_note, flag_adj_carry;
  logic flag_half, flag_zero, flag_carry, flag_neg_div, flag_zero_div, flag_neg_quot;
  logic [15:0] count_word_in, source_pointer_in, destination_pointer_in, mem_addr;
  logic [15:0] count_word, source_pointer, destination_pointer;
  logic [7:0] mem_rdata, mem_wdata;
  logic [31:0] flag_a, flag_b, flag_res;
  bms_fop_t flag_op;
  int bad_count;
  int checked;
  int cyc;

  bms_sequencer bms_sequencer_i (.clk(clk), .reset_n(reset_n), .start(start), .word_mode(word_mode),
    .count_word_in(count_word_in), .source_pointer_in(source_pointer_in),
    .destination_pointer_in(destination_pointer_in), .mem_slow_wait(mem_slow_wait), .mem_rdata(mem_rdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .done(done),
    .count_word(count_word), .source_pointer(source_pointer), .destination_pointer(destination_pointer),
    .flag_op(flag_op), .flag_strobe(flag_strobe), .flag_a(flag_a), .flag_b(flag_b), .flag_res(flag_res),
    .flag_zero_note(flag_zero_note), .flag_adj_carry(flag_adj_carry), .flag_half(flag_half),
    .flag_zero(flag_zero), .flag_carry(flag_carry), .flag_neg_div(flag_neg_div),
    .flag_zero_div(flag_zero_div), .flag_neg_quot(flag_neg_quot));

  bms_mem_model bms_mem_model_i (.clk(clk), .reset_n(reset_n), .slow(slow), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_slow_wait(mem_slow_wait), .mem_rdata(mem_rdata));

  // 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // -----------------------------------------------------------------------------
  // Shared tasks.
  // -----------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Starts a move, optionally pokes a second start mid-move, counts cycles to done.
  task automatic run_move(input logic wm, input logic [15:0] cnt, input logic [15:0] src,
    input logic [15:0] dst, input logic poke);
    @(posedge clk);
    start <= 1'b1;
    word_mode <= wm;
    count_word_in <= cnt;
    source_pointer_in <= src;
    destination_pointer_in <= dst;
    bms_mem_model_i.stall_count = 0;
    @(posedge clk);
    start <= 1'b0;
    cyc = 0;
    while (cyc < 3000)
    begin
      @(posedge clk);
      start <= poke && (cyc == 3);
      count_word_in <= 16'h0009;
      source_pointer_in <= 16'hff00;
      #1;
      cyc++;
      if (cyc == 1)
        chk("busy", busy, 1'b1);
      if (done === 1'b1)
        break;
    end
    chk("idle after done", busy, 1'b0);
    @(posedge clk);
    #1;
    chk("done pulse", done, 1'b0);
  endtask : run_move

  task automatic chk_copy(input logic [15:0] src, input logic [15:0] dst, input int n);
    for (int k = 0; k < n; k++)
      chk("copied byte", bms_mem_model_i.mem[16'(dst + k)], 8'(16'(src + k)) ^ 8'h5a);
  endtask : chk_copy

  task automatic flg(input bms_fop_t op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] r,
    input logic note, input logic adj);
    @(posedge clk);
    flag_op <= op;
    flag_a <= a;
    flag_b <= b;
    flag_res <= r;
    flag_zero_note <= note;
    flag_adj_carry <= adj;
    flag_strobe <= 1'b1;
    @(posedge clk);
    flag_strobe <= 1'b0;
    @(posedge clk);
    #1;
  endtask : flg

  // -----------------------------------------------------------------------------
  // Scenarios.
  // -----------------------------------------------------------------------------
  task automatic t_byte;
    run_move(1'b0, 16'h1203, 16'h0100, 16'h2000, 1'b1);
    chk("byte cycles", cyc, 8 + 4 * 3);
    chk("byte count", count_word, 16'h1200);
    chk("byte src", source_pointer, 16'h0103);
    chk("byte dst", destination_pointer, 16'h2003);
    chk_copy(16'h0100, 16'h2000, 3);
    chk("byte past end", bms_mem_model_i.mem[16'h2003], 8'h03 ^ 8'h5a);
  endtask : t_byte

  task automatic t_zero;
    int w0;
    w0 = bms_mem_model_i.wr_count;
    run_move(1'b0, 16'h0500, 16'h0300, 16'h3000, 1'b0);
    chk("zero cycles", cyc, 8);
    chk("zero src", source_pointer, 16'h0300);
    chk("zero count", count_word, 16'h0500);
    run_move(1'b1, 16'h0000, 16'h0300, 16'h3000, 1'b0);
    chk("zero word cycles", cyc, 8);
    chk("zero writes", bms_mem_model_i.wr_count - w0, 0);
  endtask : t_zero

  task automatic t_word;
    run_move(1'b1, 16'h0100, 16'h0400, 16'h4000, 1'b0);
    chk("word cycles", cyc, 8 + 4 * 256);
    chk("word count", count_word, 16'h0000);
    chk("word src", source_pointer, 16'h0500);
    chk("word dst", destination_pointer, 16'h4100);
    chk_copy(16'h0400, 16'h4000, 256);
  endtask : t_word

  task automatic t_stall;
    slow <= 1'b1;
    run_move(1'b0, 16'h0002, 16'h0600, 16'h6000, 1'b0);
    slow <= 1'b0;
    chk("stall cycles", cyc, 8 + 4 * 2 + 4);
    chk("stall seen", bms_mem_model_i.stall_count, 4);
    chk_copy(16'h0600, 16'h6000, 2);
  endtask : t_stall

  task automatic t_flags;
    flg(BMS_FOP_ADDW, 32'h0000_0800, 32'h0000_0800, 32'h0000_1000, 1'b0, 1'b0);
    chk("half addw carry", flag_half, 1'b1);
    flg(BMS_FOP_ADDW, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0);
    chk("zero plain", flag_zero, 1'b1);
    flg(BMS_FOP_ADDW, 32'h0000_0800, 32'hffff_f800, 32'h0000_0000, 1'b1, 1'b0);
    chk("zero note kept", flag_zero, 1'b1);
    chk("half addw wrap", flag_half, 1'b1);
    flg(BMS_FOP_ADDW, 32'h0000_0400, 32'h0000_0400, 32'h0000_0800, 1'b1, 1'b0);
    chk("half addw none", flag_half, 1'b0);
    chk("zero note nonzero", flag_zero, 1'b0);
    flg(BMS_FOP_SUBW, 32'h0000_1000, 32'h0000_0001, 32'h0000_0fff, 1'b0, 1'b0);
    chk("half subw borrow", flag_half, 1'b1);
    flg(BMS_FOP_ADDL, 32'h0800_0000, 32'h0800_0000, 32'h1000_0000, 1'b0, 1'b0);
    chk("half addl carry", flag_half, 1'b1);
    flg(BMS_FOP_SUBL, 32'h0000_1000, 32'h0000_0001, 32'h0000_0fff, 1'b0, 1'b0);
    chk("half subl none", flag_half, 1'b0);
    flg(BMS_FOP_ADJ, 32'h0000_0099, 32'h0000_0066, 32'h0000_0000, 1'b0, 1'b1);
    chk("carry adjust set", flag_carry, 1'b1);
    flg(BMS_FOP_ADJ, 32'h0000_0011, 32'h0000_0000, 32'h0000_0011, 1'b0, 1'b0);
    chk("carry adjust kept", flag_carry, 1'b1);
    flg(BMS_FOP_DIVS, 32'h0000_0010, 32'h0000_8000, 32'h0000_0002, 1'b0, 1'b0);
    chk("neg divisor", flag_neg_div, 1'b1);
    chk("neg quot clear", flag_neg_quot, 1'b0);
    flg(BMS_FOP_DIVU, 32'h0000_0010, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0);
    chk("zero divisor", flag_zero_div, 1'b1);
    flg(BMS_FOP_DIVS, 32'h0000_0010, 32'h0000_0003, 32'h0000_8000, 1'b0, 1'b0);
    chk("neg quot set", flag_neg_quot, 1'b1);
    chk("pos divisor", flag_neg_div, 1'b0);
    chk("nonzero divisor", flag_zero_div, 1'b0);
  endtask : t_flags

  // Cuts a move short with reset, then checks that a fresh move still runs.
  task automatic t_reset;
    @(posedge clk);
    start <= 1'b1;
    word_mode <= 1'b0;
    count_word_in <= 16'h0005;
    source_pointer_in <= 16'h0700;
    destination_pointer_in <= 16'h7000;
    @(posedge clk);
    start <= 1'b0;
    repeat (9) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset busy", busy, 1'b0);
    chk("reset write", mem_wr, 1'b0);
    chk("reset count", count_word, 16'h0000);
    chk("reset carry", flag_carry, 1'b0);
    chk("reset cut write", bms_mem_model_i.mem[16'h7000], 8'h5a);
    @(posedge clk);
    reset_n <= 1'b1;
    run_move(1'b0, 16'h0001, 16'h0800, 16'h7800, 1'b0);
    chk("reset rerun cycles", cyc, 8 + 4 * 1);
    chk_copy(16'h0800, 16'h7800, 1);
  endtask : t_reset

  // Cuts a hang short well past the longest expected run.
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    {reset_n, start, word_mode, slow, flag_strobe, flag_zero_note, flag_adj_carry} = 7'h00;
    {count_word_in, source_pointer_in, destination_pointer_in} = 48'h0;
    {flag_a, flag_b, flag_res} = 96'h0;
    flag_op = BMS_FOP_NONE;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_byte();
    t_zero();
    t_word();
    t_stall();
    t_flags();
    t_reset();
    report_and_stop();
  end
endmodule : bms_sequencer_tb
